// file: hw/conv_src_timer.sv
// conversion signal source selection and frame timer with apb registers
`timescale 1ns/1ns
module conv_src_timer
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire conv_src_pkg::sig_inputs_s trig_in,
  input  wire conv_src_pkg::sig_inputs_s clk1_in,
  input  wire conv_src_pkg::sig_inputs_s clk2_in,
  output conv_src_pkg::conv_ctrl_s       conv_ctrl,
  output logic                           frame_timer_event,
  output logic                           irq
);

  typedef struct packed {
    conv_src_pkg::source_sel_s src;
    logic                      enable;
    logic                      clk_sel;
    logic                      flag;
    logic [27:0]               reload;
    logic [27:0]               count;
    logic                      running;
    logic                      trig_d;
    logic                      tclk_d;
    conv_src_pkg::irq_bits_s   status;
    conv_src_pkg::irq_bits_s   mask;
    conv_src_pkg::conv_ctrl_s  ctrl;
    logic                      event_p;
    logic                      irq;
    logic [31:0]               rdata;
    logic                      ready;
    logic                      err;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // one source mux used for all three signals
  function automatic logic pick_source(input logic [1:0] sel,
                                       input conv_src_pkg::sig_inputs_s s);
    logic r;
    r = s.gen;
    if (sel == conv_src_pkg::src_rear)
      r = s.rear;
    else if (sel == conv_src_pkg::src_front)
      r = s.front;
    return r;
  endfunction : pick_source

  logic sel_trig;
  logic sel_clk1;
  logic sel_clk2;
  logic tclk;
  logic trig_rise;
  logic tclk_rise;
  logic access;
  logic wr;
  logic expire;
  logic known_addr;

  always_comb
  begin
    sel_trig = pick_source(st_r.src.trig, trig_in);
    sel_clk1 = pick_source(st_r.src.clk1, clk1_in);
    sel_clk2 = pick_source(st_r.src.clk2, clk2_in);
    tclk = st_r.clk_sel ? sel_clk2 : sel_clk1;
    // edges are detected in pclk; source signals must be slower than pclk/2
    trig_rise = sel_trig & ~st_r.trig_d;
    tclk_rise = tclk & ~st_r.tclk_d;
    access = psel & penable & ~st_r.ready;
    // writes commit at the completing edge, while pready stands high
    wr = psel & penable & pwrite & st_r.ready;
    known_addr = (paddr == conv_src_pkg::source_select_addr) ||
                 (paddr == conv_src_pkg::frame_timer_addr) ||
                 (paddr == conv_src_pkg::irq_status_addr) ||
                 (paddr == conv_src_pkg::irq_mask_addr);
    // expires on the clock rise seen while count equals reload, so reload plus one rises in all
    expire = st_r.enable & st_r.running & tclk_rise & ~trig_rise &
             (st_r.count == st_r.reload);
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.trig_d = sel_trig;
    st_nxt.tclk_d = tclk;
    // route selected signals to the sequencers
    st_nxt.ctrl.frame_trigger = sel_trig;
    st_nxt.ctrl.clk1 = sel_clk1;
    st_nxt.ctrl.clk2 = sel_clk2;
    st_nxt.event_p = 1'b0;

    if (wr && paddr == conv_src_pkg::source_select_addr)
      st_nxt.src = pwdata[conv_src_pkg::trig_src_lsb + 1:0];
    if (wr && paddr == conv_src_pkg::frame_timer_addr)
    begin
      st_nxt.enable = pwdata[conv_src_pkg::timer_enable_pos];
      st_nxt.clk_sel = pwdata[conv_src_pkg::timer_clock_pos];
      st_nxt.reload = pwdata[conv_src_pkg::value_width - 1:0];
    end
    if (wr && paddr == conv_src_pkg::irq_mask_addr)
      st_nxt.mask = pwdata[1:0];
    // write one to clear; a new event below wins
    if (wr && paddr == conv_src_pkg::irq_status_addr)
      st_nxt.status = st_r.status & ~pwdata[1:0];

    if (!st_r.enable)
      st_nxt.running = 1'b0;
    else if (trig_rise)
    begin
      st_nxt.running = 1'b1;
      st_nxt.count = '0;
    end
    else if (expire)
    begin
      st_nxt.running = 1'b0;
      st_nxt.count = '0;
    end
    else if (st_r.running && tclk_rise)
      st_nxt.count = st_r.count + conv_src_pkg::count_one;

    // any trigger clears the flag, even with the timer disabled
    if (trig_rise)
      st_nxt.flag = 1'b0;
    // expiry sets the flag and pulses the event
    if (expire)
    begin
      st_nxt.flag = 1'b1;
      st_nxt.event_p = 1'b1;
      st_nxt.status.expiry = 1'b1;
    end
    if (st_r.enable && trig_rise)
      st_nxt.status.trig_event = 1'b1;
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);

    st_nxt.ready = access;
    st_nxt.err = access & ~known_addr;
    st_nxt.rdata = '0;
    if (access && !pwrite)
    begin
      unique case (paddr)
        conv_src_pkg::source_select_addr: st_nxt.rdata = {26'h0, st_r.src};
        conv_src_pkg::frame_timer_addr:
          st_nxt.rdata = {st_r.enable, st_r.clk_sel, st_r.flag, 1'b0,
                          st_r.reload};
        conv_src_pkg::irq_status_addr: st_nxt.rdata = {30'h0, st_r.status};
        conv_src_pkg::irq_mask_addr:   st_nxt.rdata = {30'h0, st_r.mask};
        default:                       st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
      st_r.reload <= conv_src_pkg::reload_reset;
    end
    else
      st_r <= st_nxt;
  end

  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.err;
  assign conv_ctrl = st_r.ctrl;
  assign frame_timer_event = st_r.event_p;
  assign irq = st_r.irq;

  chk_flag_on_expiry: assert property (
    @(posedge pclk) disable iff (!presetn)
    expire |=> st_r.flag && frame_timer_event)
    else $error("flag not set on expiry");

  chk_flag_trig_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    trig_rise |=> !st_r.flag)
    else $error("flag not cleared by trigger");

  chk_restart_count: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.enable && trig_rise |=> st_r.running && st_r.count == '0)
    else $error("trigger did not restart timer");

  chk_disabled_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    !st_r.enable |=> !st_r.running && !frame_timer_event)
    else $error("disabled timer active");

  chk_stop_after: assert property (
    @(posedge pclk) disable iff (!presetn)
    expire |=> !st_r.running)
    else $error("timer kept running after expiry");

  chk_route_trig: assert property (
    @(posedge pclk) disable iff (!presetn)
    conv_ctrl.frame_trigger == $past(sel_trig))
    else $error("trigger not routed");

  chk_src_rear: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.src.trig == conv_src_pkg::src_rear |-> sel_trig == trig_in.rear)
    else $error("rear trigger not selected");

  chk_clk_choice: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.enable && st_r.running && !st_r.clk_sel && $stable(st_r.clk_sel) &&
    $rose(sel_clk1) && !trig_rise && st_r.count != st_r.reload
    |=> st_r.count == $past(st_r.count) + conv_src_pkg::count_one)
    else $error("clock 1 edge not counted");

  chk_count_clk2: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.enable && st_r.running && st_r.clk_sel && $stable(st_r.clk_sel) &&
    $rose(sel_clk2) && !trig_rise && st_r.count != st_r.reload
    |=> st_r.count == $past(st_r.count) + conv_src_pkg::count_one)
    else $error("clock 2 edge not counted");

  chk_expire_value: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.enable && st_r.running && tclk_rise && !trig_rise &&
    st_r.count == st_r.reload |=> frame_timer_event && !st_r.running)
    else $error("timer did not expire at reload value");

  chk_no_early_expiry: assert property (
    @(posedge pclk) disable iff (!presetn)
    frame_timer_event |-> $past(st_r.count) == $past(st_r.reload))
    else $error("timer expired before reload value");

  chk_clk2_front: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.src.clk2 == conv_src_pkg::src_front |-> sel_clk2 == clk2_in.front)
    else $error("front clock 2 not selected");

  chk_clk1_gen: assert property (
    @(posedge pclk) disable iff (!presetn)
    !st_r.src.clk1[1] |-> sel_clk1 == clk1_in.gen)
    else $error("generator clock 1 not selected");

  chk_src_front: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.src.trig == conv_src_pkg::src_front |-> sel_trig == trig_in.front)
    else $error("front trigger not selected");

  chk_src_gen: assert property (
    @(posedge pclk) disable iff (!presetn)
    !st_r.src.trig[1] |-> sel_trig == trig_in.gen)
    else $error("generator trigger not selected");

  chk_clk2_rear: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.src.clk2 == conv_src_pkg::src_rear |-> sel_clk2 == clk2_in.rear)
    else $error("rear clock 2 not selected");

  chk_clk2_gen: assert property (
    @(posedge pclk) disable iff (!presetn)
    !st_r.src.clk2[1] |-> sel_clk2 == clk2_in.gen)
    else $error("generator clock 2 not selected");

  chk_clk1_rear: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.src.clk1 == conv_src_pkg::src_rear |-> sel_clk1 == clk1_in.rear)
    else $error("rear clock 1 not selected");

  chk_clk1_front: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.src.clk1 == conv_src_pkg::src_front |-> sel_clk1 == clk1_in.front)
    else $error("front clock 1 not selected");

  chk_route_clocks: assert property (
    @(posedge pclk) disable iff (!presetn)
    conv_ctrl.clk1 == $past(sel_clk1) && conv_ctrl.clk2 == $past(sel_clk2))
    else $error("conversion clocks not routed");

  chk_trig_status: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.enable && trig_rise |=> st_r.status.trig_event)
    else $error("trigger event not recorded");

  chk_flag_readonly: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == conv_src_pkg::frame_timer_addr && !st_r.flag && !expire
    |=> !st_r.flag)
    else $error("flag set by a register write");

  chk_flag_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.flag && !trig_rise |=> st_r.flag)
    else $error("flag cleared without trigger");

  chk_event_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    frame_timer_event |=> !frame_timer_event)
    else $error("frame timer event longer than one cycle");

  chk_irq_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq == |(st_r.status & st_r.mask))
    else $error("irq does not follow unmasked status");

  chk_timer_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !st_r.enable |=> $stable(st_r.count))
    else $error("disabled timer counted");

  chk_stopped_still: assert property (
    @(posedge pclk) disable iff (!presetn)
    !st_r.running && !trig_rise |=> $stable(st_r.count))
    else $error("stopped timer counted");

  // main scenarios: expiry on either clock, restart, front trigger, irq
  cov_expiry: cover property (@(posedge pclk) disable iff (!presetn) expire);

  cov_restart: cover property (@(posedge pclk) disable iff (!presetn)
    st_r.running && trig_rise);

  cov_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
  cov_clk2_expiry: cover property (@(posedge pclk) disable iff (!presetn)
    expire && st_r.clk_sel);
  cov_front_trig: cover property (@(posedge pclk) disable iff (!presetn)
    trig_rise && st_r.src.trig == conv_src_pkg::src_front);

endmodule : conv_src_timer

// file: shared/conv_src_pkg.sv
// shared constants and types for the conversion source and frame timer block
package conv_src_pkg;

  localparam logic [11:0] source_select_addr   = 12'h344;
  localparam logic [11:0] frame_timer_addr     = 12'h348;
  localparam logic [11:0] irq_status_addr      = 12'h34C;
  localparam logic [11:0] irq_mask_addr        = 12'h350;

  localparam int unsigned first_src_lsb        = 0;
  localparam int unsigned second_src_lsb       = 2;
  localparam int unsigned trig_src_lsb         = 4;
  localparam int unsigned timer_enable_pos     = 31;
  localparam int unsigned timer_clock_pos      = 30;
  localparam int unsigned timer_flag_pos       = 29;
  localparam int unsigned value_width          = 28;

  localparam logic [1:0]  src_rear             = 2'h2;
  localparam logic [1:0]  src_front            = 2'h3;
  localparam logic [27:0] reload_reset         = 28'hFFFFFFF;
  localparam logic [27:0] count_one            = 28'h0000001;

  // decoded register word for the three source fields
  typedef struct packed {
    logic [1:0] trig;
    logic [1:0] clk2;
    logic [1:0] clk1;
  } source_sel_s;

  // one input set per selectable signal
  typedef struct packed {
    logic front;
    logic rear;
    logic gen;
  } sig_inputs_s;

  // routed conversion control signals
  typedef struct packed {
    logic frame_trigger;
    logic clk2;
    logic clk1;
  } conv_ctrl_s;

  typedef struct packed {
    logic trig_event;
    logic expiry;
  } irq_bits_s;

endpackage : conv_src_pkg

// file: verification/signal_source_model.sv
// far-side model: on-board generators, rear inputs and front lines
`timescale 1ns/1ns
module signal_source_model
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [2:0]           fire,
  output conv_src_pkg::sig_inputs_s trig_in,
  output conv_src_pkg::sig_inputs_s clk1_in,
  output conv_src_pkg::sig_inputs_s clk2_in
);
  int unsigned cnt_r;
  logic [2:0]  hold_r;

  // distinct half periods expose a wrong source pick; all stay slower
  // than pclk/2 so every edge survives the block's sampling
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r   <= 0;
      hold_r  <= 3'h0;
      trig_in <= '0;
      clk1_in <= '0;
      clk2_in <= '0;
    end
    else
    begin
      cnt_r <= cnt_r + 1;
      if (cnt_r % 8 == 0) clk1_in.gen <= ~clk1_in.gen;
      if (cnt_r % 9 == 0) clk1_in.rear <= ~clk1_in.rear;
      if (cnt_r % 10 == 0) clk1_in.front <= ~clk1_in.front;
      if (cnt_r % 11 == 0) clk2_in.gen <= ~clk2_in.gen;
      if (cnt_r % 12 == 0) clk2_in.rear <= ~clk2_in.rear;
      if (cnt_r % 13 == 0) clk2_in.front <= ~clk2_in.front;
      // trigger lines pulse for a few cycles on command only
      if (fire != 3'h0)
      begin
        trig_in <= conv_src_pkg::sig_inputs_s'(fire);
        hold_r  <= 3'h3;
      end
      else if (hold_r != 3'h0) hold_r <= hold_r - 3'h1;
      else trig_in <= '0;
    end
  end
endmodule : signal_source_model

// file: verification/tb.sv
// self-checking bench for source selection and frame timer
`timescale 1ns/1ns
module tb;
  logic                      pclk, presetn, psel, penable, pwrite;
  logic                      pready, pslverr, frame_timer_event, irq;
  logic [11:0]               paddr;
  logic [31:0]               pwdata, prdata, rd;
  logic                      err;
  logic [2:0]                fire;
  conv_src_pkg::sig_inputs_s trig_in, clk1_in, clk2_in;
  conv_src_pkg::sig_inputs_s trig_p, clk1_p, clk2_p;
  conv_src_pkg::conv_ctrl_s  conv_ctrl;
  int                        fail_count = 0;
  int                        check_count = 0;
  int                        cycles = 0;
  logic [5:0]                rows [6] = '{6'h00, 6'h15, 6'h2A, 6'h3F,
                                          6'h1B, 6'h24};

  conv_src_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_in(trig_in), .clk1_in(clk1_in), .clk2_in(clk2_in),
    .conv_ctrl(conv_ctrl), .frame_timer_event(frame_timer_event),
    .irq(irq));
  signal_source_model src_u (.pclk(pclk), .presetn(presetn), .fire(fire),
    .trig_in(trig_in), .clk1_in(clk1_in), .clk2_in(clk2_in));

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  // routing is one cycle late, so compare against last cycle's inputs
  always @(posedge pclk)
  begin
    trig_p <= trig_in;
    clk1_p <= clk1_in;
    clk2_p <= clk2_in;
    cycles <= cycles + 1;
    if (cycles == 12000)
    begin
      fail_count++;
      complete_run;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    check(32'(pready), 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  task automatic irqchk(input logic exp);
    repeat (2) @(posedge pclk);
    #1;
    check(32'(irq), 32'(exp));
  endtask : irqchk

  task automatic quiet(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      #1;
      check(32'(frame_timer_event), 32'h0);
    end
  endtask : quiet

  function automatic logic pick(input logic [1:0] c,
                                input conv_src_pkg::sig_inputs_s s);
    return c[1] ? (c[0] ? s.front : s.rear) : s.gen;
  endfunction : pick

  function automatic logic sel_clk(input logic c);
    return c ? clk2_in.gen : clk1_in.gen;
  endfunction : sel_clk

  task automatic route(input logic [5:0] s);
    conv_src_pkg::conv_ctrl_s e;
    repeat (10)
    begin
      @(posedge pclk);
      #1;
      e.frame_trigger = pick(s[5:4], trig_p);
      e.clk2 = pick(s[3:2], clk2_p);
      e.clk1 = pick(s[1:0], clk1_p);
      check({29'h0, conv_ctrl}, {29'h0, e});
    end
  endtask : route

  // trigger just after a clock fall so no rise is ambiguous
  task automatic timed(input logic c, input logic [27:0] v);
    int   n;
    logic last;
    apb(1'b1, conv_src_pkg::frame_timer_addr, {1'b1, c, 2'b10, v});
    while (sel_clk(c) !== 1'b1) @(posedge pclk);
    while (sel_clk(c) !== 1'b0) @(posedge pclk);
    fire <= 3'h1;
    @(posedge pclk);
    fire <= 3'h0;
    n = 0;
    last = 1'b0;
    do
    begin
      @(posedge pclk);
      #1;
      n += int'(sel_clk(c) & ~last);
      last = sel_clk(c);
    end
    while (frame_timer_event !== 1'b1);
    check(32'(n), 32'(v) + 32'h1);
    rdchk(conv_src_pkg::frame_timer_addr, {1'b1, c, 2'b10, v});
    quiet(50);
  endtask : timed

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, fire} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(conv_src_pkg::source_select_addr, 32'h0);
    rdchk(conv_src_pkg::frame_timer_addr, 32'h0FFFFFFF);
    apb(1'b0, 12'h354, 32'h0);
    check(32'(err), 32'h1);
    // rows also pick front lines, a test-only setting
    foreach (rows[i])
    begin
      apb(1'b1, conv_src_pkg::source_select_addr, {26'h0, rows[i]});
      rdchk(conv_src_pkg::source_select_addr, {26'h0, rows[i]});
      for (int k = 0; k < 3; k++)
      begin
        fire <= 3'h1 << k;
        @(posedge pclk);
        fire <= 3'h0;
        route(rows[i]);
      end
    end
    apb(1'b1, conv_src_pkg::source_select_addr, 32'h0);
    apb(1'b1, conv_src_pkg::irq_mask_addr, 32'h1);
    timed(1'b0, 28'h3);
    irqchk(1'b1);
    rdchk(conv_src_pkg::irq_status_addr, 32'h3);
    apb(1'b1, conv_src_pkg::irq_status_addr, 32'h1);
    irqchk(1'b0);
    apb(1'b1, conv_src_pkg::irq_mask_addr, 32'h2);
    irqchk(1'b1);
    apb(1'b1, conv_src_pkg::irq_status_addr, 32'h3);
    irqchk(1'b0);
    timed(1'b1, 28'h1);
    timed(1'b0, 28'h0);
    // a trigger with the timer off still clears the flag; bit 29 is
    // not writable, so the read below must show it low
    apb(1'b1, conv_src_pkg::frame_timer_addr, 32'h00000100);
    fire <= 3'h1;
    @(posedge pclk);
    fire <= 3'h0;
    apb(1'b1, conv_src_pkg::frame_timer_addr, 32'hA0000100);
    rdchk(conv_src_pkg::frame_timer_addr, 32'h80000100);
    apb(1'b1, conv_src_pkg::frame_timer_addr, 32'h00000002);
    fire <= 3'h1;
    @(posedge pclk);
    fire <= 3'h0;
    quiet(80);
    rdchk(conv_src_pkg::frame_timer_addr, 32'h00000002);
    // mid-run reset returns every register to its reset value
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(conv_src_pkg::frame_timer_addr, 32'h0FFFFFFF);
    rdchk(conv_src_pkg::irq_status_addr, 32'h0);
    check(32'(irq), 32'h0);
    complete_run;
  end
endmodule : tb
